// file: design/softstart_pkg.sv
// shared constants and types for the start-up and soft-start sequencer
package softstart_pkg;

  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1_000;
  localparam int unsigned MEM_CHECK_MS = 5;
  localparam int unsigned MEM_CHECK_CYC = MEM_CHECK_MS * CYC_PER_MS;
  localparam int unsigned MIN_DELAY_MS = 2;
  localparam int unsigned MIN_DELAY_CYC = MIN_DELAY_MS * CYC_PER_MS;
  localparam int unsigned RAMP_MIN_US = 500;
  localparam int unsigned RAMP_MIN_CYC = RAMP_MIN_US * CYC_PER_US;

  // ---------------------------------------------------------------------
  // configuration fields and reset values
  // ---------------------------------------------------------------------
  localparam int unsigned REF_W = 12;
  localparam int unsigned MS_W = 8;
  localparam int unsigned NVM_DEPTH = 4;
  localparam logic [1:0] NVM_ADDR_DELAY = 2'h0;
  localparam logic [1:0] NVM_ADDR_RAMP = 2'h1;
  localparam logic [1:0] NVM_ADDR_VALID = 2'h2;
  localparam logic [1:0] NVM_ADDR_TARGET = 2'h3;
  localparam logic [15:0] NVM_VALID_MARK = 16'h00_A5;
  localparam logic [MS_W-1:0] RST_DELAY_MS = 8'h05;
  localparam logic [MS_W-1:0] RST_RAMP_MS = 8'h05;
  localparam logic [REF_W-1:0] RST_TARGET = 12'h0_3E8;
  // trim resistor index that selects the module trim mode (110 kohm)
  localparam logic [5:0] TRIM_MODE_IDX = 6'h1_E;
  localparam int unsigned TRIM_KNEE_MV = 690;
  localparam int unsigned TRIM_NUM = 6900;
  // alternate trim mode series resistor in ohms
  localparam int unsigned TRIM_SERIES_OHM = 8660;

  // ---------------------------------------------------------------------
  // strap encodings
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    STRAP_LOW = 2'b00,
    STRAP_OPEN = 2'b01,
    STRAP_HIGH = 2'b10,
    STRAP_RES = 2'b11
  } strap_kind_t;

  typedef struct packed {
    strap_kind_t kind;
    logic [5:0] res_idx;
  } strap_t;

  typedef struct packed {
    logic [MS_W-1:0] delay_ms;
    logic [MS_W-1:0] ramp_ms;
    logic undervoltage_lockout_level_high;
  } ss_cfg_t;

  typedef struct packed {
    logic wr;
    logic restore;
    logic [MS_W-1:0] delay_ms;
    logic [MS_W-1:0] ramp_ms;
  } cmd_t;

  typedef enum logic [2:0] {
    ST_MEMCHK = 3'b000,
    ST_LOAD = 3'b001,
    ST_PINS = 3'b010,
    ST_READY = 3'b011,
    ST_DELAY = 3'b100,
    ST_RAMP = 3'b101,
    ST_ON = 3'b110
  } seq_state_t;

endpackage

// file: design/cfg_store.sv
// small stored-configuration memory with registered read data
module cfg_store #(
  parameter int unsigned DEPTH = 4,
  parameter int unsigned WIDTH = 16
) (
  // clock and control
  input wire logic i_sys_clk,
  input wire logic i_ce,
  // write port
  input wire logic i_wr,
  input wire logic [$clog2(DEPTH)-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  // read port
  input wire logic [$clog2(DEPTH)-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  // refuse a memory too small to address
  if (DEPTH < 2) $error("cfg_store depth too small");

  // write and registered read
  always_ff @(posedge i_sys_clk) begin
    if (i_ce) begin
      if (i_wr) mem_r[i_waddr] <= i_wdata;
      o_rdata <= mem_r[i_raddr];
    end
  end

endmodule

// file: design/softstart_seq.sv
// start-up, strap decode, pre-ramp delay and soft-start ramp sequencer
// ---------------------------------------------------------------------
// Overview of operation
// - after power-up check stored memory about 5-10 ms, load values found
// - then sample every multi-mode strap and load its settings
// - a restore command reruns the memory check
// - ready state reached only after loading; then commands and enable work
// - pre-ramp delay never below 2 ms; short delays become 2 ms
// - delays longer than 2 ms are waited in full
// - when delay ends, ramp output to target over configured ramp time
// - delay timer starts at enable and stops when delay has elapsed
// - ramp is monotonic and its slope follows ramp-time selection
// - soft-start strap picks delay, ramp and undervoltage lockout level
// - soft-start resistor read only at start-up or restore
// - custom delay and ramp times written by command replace strap values
// - zero delay starts ramp after about 2 ms initialisation
// - alternate trim mode maps resistance by 6900 over volts above 0.69
// - 110 kohm on low voltage-select pin enters trim mode via high pin
// ---------------------------------------------------------------------
module softstart_seq #(
  parameter int unsigned MEM_CHECK_CYC = softstart_pkg::MEM_CHECK_CYC,
  parameter int unsigned MIN_DELAY_CYC = softstart_pkg::MIN_DELAY_CYC,
  parameter int unsigned CYC_PER_MS = softstart_pkg::CYC_PER_MS,
  parameter int unsigned STEPS = 256
) (
  // clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  // host side
  input wire logic i_enable,
  input wire softstart_pkg::cmd_t i_cmd,
  input wire logic i_trim_alt,
  // strap pins, already resolved to kind and resistor index
  input wire softstart_pkg::strap_t i_ss_strap,
  input wire softstart_pkg::strap_t i_voltage_select_low_pin,
  input wire softstart_pkg::strap_t i_voltage_select_high_pin,
  // stored configuration programming port
  input wire logic i_nvm_wr,
  input wire logic [1:0] i_nvm_addr,
  input wire logic [15:0] i_nvm_wdata,
  // status and outputs
  output logic o_ready,
  output logic o_ramping,
  output logic o_ramp_done,
  output logic o_undervoltage_lockout_level,
  output logic o_trim_mode,
  output logic [softstart_pkg::REF_W-1:0] o_vref,
  output logic [softstart_pkg::REF_W-1:0] o_target,
  output softstart_pkg::ss_cfg_t o_cfg
);

  localparam int unsigned CNT_W = 32;

  // refuse parameter values that the counters cannot serve
  if (STEPS < 2 || STEPS > 4096) $error("bad STEPS");
  if (MEM_CHECK_CYC < 1 || MIN_DELAY_CYC < 1 || CYC_PER_MS < 1)
    $error("bad timing");

  // ---------------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------------
  function automatic logic [7:0] ms_sel(input logic [1:0] code);
    case (code)
      2'd0: ms_sel = 8'h02;
      2'd1: ms_sel = 8'h05;
      2'd2: ms_sel = 8'h0A;
      default: ms_sel = 8'h14;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] ms_to_cyc(input logic [7:0] ms);
    ms_to_cyc = CNT_W'(ms) * CNT_W'(CYC_PER_MS);
  endfunction

  // soft-start strap decode: index 0..31 (higher clamps to 31) = two lockout halves of four delay groups of four ramps
  function automatic softstart_pkg::ss_cfg_t ss_decode(
      input softstart_pkg::strap_t s);
    softstart_pkg::ss_cfg_t c;
    logic [5:0] idx;
    logic [1:0] dg;
    c = '0;
    idx = s.res_idx;
    dg = 2'd0;
    case (s.kind)
      softstart_pkg::STRAP_LOW: begin
        c.delay_ms = ms_sel(2'd0);
        c.ramp_ms = ms_sel(2'd0);
      end
      softstart_pkg::STRAP_OPEN: begin
        c.delay_ms = ms_sel(2'd1);
        c.ramp_ms = ms_sel(2'd1);
      end
      softstart_pkg::STRAP_HIGH: begin
        c.delay_ms = ms_sel(2'd2);
        c.ramp_ms = ms_sel(2'd2);
      end
      default: begin
        // index 0..2 have a 2 ms delay, 0..15 low lockout, 16..31 high
        if (idx > 6'd31) idx = 6'd31;
        dg = idx[3:2];
        c.delay_ms = (idx == 6'd0) ? 8'h00 : ms_sel(dg);
        if (idx[5:4] == 2'd0) c.delay_ms = (idx < 6'd3) ? 8'h02 : c.delay_ms;
        c.ramp_ms = ms_sel(idx[1:0]);
        c.undervoltage_lockout_level_high = idx[4];
      end
    endcase
    ss_decode = c;
  endfunction

  // trim decode: target millivolts = 690 + 6900*k / resistance
  function automatic logic [11:0] trim_mv(input logic [5:0] idx,
                                          input logic alt);
    logic [31:0] r_ohm;
    logic [31:0] q;
    r_ohm = 32'd1000 + 32'(idx) * 32'd3000;
    if (alt) r_ohm = r_ohm + 32'(softstart_pkg::TRIM_SERIES_OHM);
    else r_ohm = r_ohm + 32'd10000;
    q = 32'(softstart_pkg::TRIM_NUM) * 32'd1000 / r_ohm;
    trim_mv = 12'(32'(softstart_pkg::TRIM_KNEE_MV) + q);
  endfunction

  function automatic logic [11:0] std_mv(input softstart_pkg::strap_t lo,
                                         input softstart_pkg::strap_t hi);
    logic [3:0] n;
    n = 4'(lo.kind) + 4'(hi.kind) * 4'd3;
    std_mv = 12'd600 + 12'(n) * 12'd300;
  endfunction

  // ---------------------------------------------------------------------
  // two-stage input synchroniser for the enable pin
  // ---------------------------------------------------------------------
  logic en_m_r;
  logic en_s_r;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      en_m_r <= 1'b0;
      en_s_r <= 1'b0;
    end else if (i_ce) begin
      en_m_r <= i_enable;
      en_s_r <= en_m_r;
    end
  end

  // ---------------------------------------------------------------------
  // stored configuration
  // ---------------------------------------------------------------------
  logic [1:0] nvm_raddr_r;
  logic [15:0] nvm_rdata;
  cfg_store #(.DEPTH(softstart_pkg::NVM_DEPTH), .WIDTH(16)) u_store (
    .i_sys_clk(i_sys_clk),
    .i_ce(i_ce),
    .i_wr(i_nvm_wr),
    .i_waddr(i_nvm_addr),
    .i_wdata(i_nvm_wdata),
    .i_raddr(nvm_raddr_r),
    .o_rdata(nvm_rdata)
  );

  // ---------------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------------
  softstart_pkg::seq_state_t state_r;
  softstart_pkg::seq_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] delay_cyc_r;
  logic [CNT_W-1:0] step_cyc_r;
  logic [CNT_W-1:0] step_cnt_r;
  logic [12:0] step_idx_r;
  logic [2:0] ld_cnt_r;
  logic nvm_ok_r;
  logic [15:0] nvm_delay_r;
  logic [15:0] nvm_ramp_r;
  logic [15:0] nvm_target_r;

  wire cmd_ok = (state_r != softstart_pkg::ST_MEMCHK) &&
                (state_r != softstart_pkg::ST_LOAD) &&
                (state_r != softstart_pkg::ST_PINS);
  wire restore_go = cmd_ok && i_cmd.restore;
  wire enable_ok = (state_r == softstart_pkg::ST_READY) && en_s_r;
  wire memchk_done = (cnt_r >= CNT_W'(MEM_CHECK_CYC) - 1);
  wire delay_done = (cnt_r >= delay_cyc_r - 1);
  wire ramp_last = (step_idx_r >= 13'(STEPS));

  wire softstart_pkg::ss_cfg_t strap_cfg = ss_decode(i_ss_strap);
  wire trim_sel = (i_voltage_select_low_pin.kind == softstart_pkg::STRAP_RES)
               && (i_voltage_select_low_pin.res_idx ==
                   softstart_pkg::TRIM_MODE_IDX);
  wire [11:0] pin_target = trim_sel ?
      trim_mv(i_voltage_select_high_pin.res_idx, i_trim_alt) :
      std_mv(i_voltage_select_low_pin, i_voltage_select_high_pin);

  // longer of 2 ms floor and configured delay; zero also gets the floor
  wire [CNT_W-1:0] cfg_delay_cyc = ms_to_cyc(o_cfg.delay_ms);
  wire [CNT_W-1:0] eff_delay_cyc = (cfg_delay_cyc < CNT_W'(MIN_DELAY_CYC)) ?
      CNT_W'(MIN_DELAY_CYC) : cfg_delay_cyc;
  // ramp step spacing, at least one cycle per step
  wire [CNT_W-1:0] raw_step = ms_to_cyc(o_cfg.ramp_ms) / CNT_W'(STEPS);
  wire [CNT_W-1:0] eff_step = (raw_step == '0) ? CNT_W'(1) : raw_step;

  // next-state decode
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      softstart_pkg::ST_MEMCHK:
        if (memchk_done) state_nxt = softstart_pkg::ST_LOAD;
      softstart_pkg::ST_LOAD:
        if (ld_cnt_r == 3'd5) state_nxt = softstart_pkg::ST_PINS;
      softstart_pkg::ST_PINS: state_nxt = softstart_pkg::ST_READY;
      softstart_pkg::ST_READY:
        if (enable_ok) state_nxt = softstart_pkg::ST_DELAY;
      softstart_pkg::ST_DELAY:
        if (!en_s_r) state_nxt = softstart_pkg::ST_READY;
        else if (delay_done) state_nxt = softstart_pkg::ST_RAMP;
      softstart_pkg::ST_RAMP:
        if (!en_s_r) state_nxt = softstart_pkg::ST_READY;
        else if (ramp_last) state_nxt = softstart_pkg::ST_ON;
      softstart_pkg::ST_ON:
        if (!en_s_r) state_nxt = softstart_pkg::ST_READY;
      default: state_nxt = softstart_pkg::ST_MEMCHK;
    endcase
    if (restore_go) state_nxt = softstart_pkg::ST_MEMCHK;
  end

  // state register and memory-check timer
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_r <= softstart_pkg::ST_MEMCHK;
      cnt_r <= '0;
    end else if (i_ce) begin
      state_r <= state_nxt;
      if (state_nxt != state_r) cnt_r <= '0;
      else cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // stored-value fetch, one address per cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ld_cnt_r <= '0;
      nvm_raddr_r <= '0;
      nvm_ok_r <= 1'b0;
      nvm_delay_r <= '0;
      nvm_ramp_r <= '0;
      nvm_target_r <= '0;
    end else if (i_ce) begin
      if (state_r == softstart_pkg::ST_LOAD) begin
        ld_cnt_r <= ld_cnt_r + 3'd1;
        nvm_raddr_r <= nvm_raddr_r + 2'd1;
        case (ld_cnt_r)
          3'd1: nvm_delay_r <= nvm_rdata;
          3'd2: nvm_ramp_r <= nvm_rdata;
          3'd3: nvm_ok_r <= (nvm_rdata == softstart_pkg::NVM_VALID_MARK);
          3'd4: nvm_target_r <= nvm_rdata;
          default: ;
        endcase
      end else begin
        ld_cnt_r <= '0;
        nvm_raddr_r <= softstart_pkg::NVM_ADDR_DELAY;
      end
    end
  end

  // configuration: straps then stored values, later custom commands
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_cfg <= '{softstart_pkg::RST_DELAY_MS, softstart_pkg::RST_RAMP_MS,
                 1'b0};
      o_target <= softstart_pkg::RST_TARGET;
      o_trim_mode <= 1'b0;
      o_undervoltage_lockout_level <= 1'b0;
    end else if (i_ce) begin
      if (state_r == softstart_pkg::ST_PINS) begin
        o_cfg <= strap_cfg;
        o_target <= pin_target;
        o_trim_mode <= trim_sel;
        o_undervoltage_lockout_level <= strap_cfg.undervoltage_lockout_level_high;
        if (nvm_ok_r) begin
          o_cfg.delay_ms <= nvm_delay_r[7:0];
          o_cfg.ramp_ms <= nvm_ramp_r[7:0];
          o_target <= nvm_target_r[11:0];
        end
      end else if (cmd_ok && i_cmd.wr) begin
        o_cfg.delay_ms <= i_cmd.delay_ms;
        o_cfg.ramp_ms <= i_cmd.ramp_ms;
      end
    end
  end

  // delay latch and ramp stepping
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      delay_cyc_r <= CNT_W'(MIN_DELAY_CYC);
      step_cyc_r <= CNT_W'(1);
      step_cnt_r <= '0;
      step_idx_r <= '0;
      o_vref <= '0;
    end else if (i_ce) begin
      if (state_r == softstart_pkg::ST_READY) begin
        delay_cyc_r <= eff_delay_cyc;
        step_cyc_r <= eff_step;
        step_cnt_r <= '0;
        step_idx_r <= '0;
        o_vref <= '0;
      end else if (state_r == softstart_pkg::ST_RAMP && !ramp_last) begin
        if (step_cnt_r >= step_cyc_r - 1) begin
          step_cnt_r <= '0;
          step_idx_r <= step_idx_r + 13'd1;
          // equal steps, never decreasing
          o_vref <= 12'((32'(o_target) * 32'(step_idx_r + 13'd1)) /
                        32'(STEPS));
        end else begin
          step_cnt_r <= step_cnt_r + CNT_W'(1);
        end
      end else if (state_r == softstart_pkg::ST_ON) begin
        o_vref <= o_target;
      end
    end
  end

  // status flags
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_ready <= 1'b0;
      o_ramping <= 1'b0;
      o_ramp_done <= 1'b0;
    end else if (i_ce) begin
      o_ready <= cmd_ok;
      o_ramping <= (state_nxt == softstart_pkg::ST_RAMP);
      o_ramp_done <= (state_nxt == softstart_pkg::ST_ON);
    end
  end

endmodule

// file: tb/softstart_host.sv
// host model that drives the enable pin and configuration commands
module softstart_host (
  // clock
  input wire logic i_sys_clk,
  // pins toward the sequencer
  output logic o_enable,
  output softstart_pkg::cmd_t o_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle values before the first request
  initial begin
    o_enable = 1'b0;
    o_cmd = '0;
  end
  // enable is a level; the single clock is always stable beforehand
  task automatic set_en(input logic v);
    @(negedge i_sys_clk);
    o_enable <= v;
  endtask
  // one-cycle command pulse; fields turn to junk once it is over
  task automatic cmd(input logic w, input logic r, input logic [7:0] d,
                     input logic [7:0] m);
    @(negedge i_sys_clk);
    o_cmd <= {w, r, d, m};
    @(negedge i_sys_clk);
    o_cmd <= {2'b00, ~d, ~m};
  endtask
endmodule

// file: tb/softstart_seq_checker.sv
// concurrent assertions on the soft-start sequencer ports
module softstart_seq_checker #(
  parameter int unsigned MIN_DELAY_CYC = 20
) (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_enable,
  input wire softstart_pkg::cmd_t i_cmd,
  input wire logic o_ready,
  input wire logic o_ramping,
  input wire logic o_ramp_done,
  input wire logic o_trim_mode,
  input wire logic [softstart_pkg::REF_W-1:0] o_vref,
  input wire logic [softstart_pkg::REF_W-1:0] o_target,
  input wire softstart_pkg::ss_cfg_t o_cfg
);
  int unsigned en_cnt_r;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // cycles that the enable pin has stayed high
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !i_enable)
      en_cnt_r <= 0;
    else
      en_cnt_r <= en_cnt_r + 1;
  end
  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  a_busy_after_reset: assert property ($fell(i_reset) |-> !o_ready [*8])
    else $error("ready too soon after reset");
  a_ramp_when_ready: assert property (o_ramping |-> o_ready)
    else $error("ramping outside ready state");
  a_delay_floor: assert property ($rose(o_ramping) |->
    en_cnt_r >= MIN_DELAY_CYC) else $error("ramp began before min delay");
  a_ramp_monotonic: assert property (o_ramping && $past(o_ramping) |->
    o_vref >= $past(o_vref)) else $error("reference stepped back");
  a_ramp_from_zero: assert property ($rose(o_ramping) |->
    $past(o_vref) == 0) else $error("ramp did not start at zero");
  a_done_at_target: assert property (o_ramp_done |->
    o_vref == o_target && !o_ramping) else $error("done off target");
  a_vref_bounded: assert property (o_ready |-> o_vref <= o_target)
    else $error("reference above target");
  a_abort_zero: assert property ((o_ready && !i_enable) [*5] |->
    o_vref == 0 && !o_ramping && !o_ramp_done)
    else $error("output not idle while disabled");
  a_cfg_write: assert property (o_ready && i_ce && i_cmd.wr &&
    !i_cmd.restore |=> o_cfg.delay_ms == $past(i_cmd.delay_ms) &&
    o_cfg.ramp_ms == $past(i_cmd.ramp_ms)) else $error("write not taken");
  a_restore_drop: assert property (o_ready && i_ce && i_cmd.restore |->
    ##[1:2] !o_ready) else $error("restore did not rerun check");
  a_cfg_hold: assert property (o_ready && $past(o_ready) &&
    !$past(i_cmd.wr) |-> $stable(o_cfg)) else $error("config changed alone");
  c_ramp: cover property ($rose(o_ramping));
  c_done: cover property ($rose(o_ramp_done));
  c_restore: cover property (o_ready && i_cmd.restore);
  c_trim: cover property ($rose(o_trim_mode));
endmodule

bind softstart_seq softstart_seq_checker #(
  .MIN_DELAY_CYC(MIN_DELAY_CYC)
) u_chk (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_ce(i_ce),
  .i_enable(i_enable), .i_cmd(i_cmd), .o_ready(o_ready),
  .o_ramping(o_ramping), .o_ramp_done(o_ramp_done),
  .o_trim_mode(o_trim_mode), .o_vref(o_vref), .o_target(o_target),
  .o_cfg(o_cfg));

// file: tb/softstart_seq_test.sv
// self-checking bench for the start-up and soft-start sequencer
module softstart_seq_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MC = 50;
  localparam int MD = 20;
  localparam int CPM = 10;
  localparam int ST = 4;
  logic i_sys_clk = 1'b0;
  logic i_reset = 1'b1;
  logic enable;
  softstart_pkg::cmd_t cmd;
  logic trim_alt = 1'b0;
  softstart_pkg::strap_t ss_strap;
  softstart_pkg::strap_t lo_pin;
  softstart_pkg::strap_t hi_pin;
  logic nvm_wr = 1'b0;
  logic [1:0] nvm_addr = 2'h0;
  logic [15:0] nvm_wdata = 16'h0000;
  logic ready, ramping, done, undervoltage_lockout_level, trim;
  logic [11:0] vref, target;
  softstart_pkg::ss_cfg_t cfg;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  int t0;
  integer seed = 32'ha1aa_2c83;
  int dq[$];
  // clock and cycle count
  always #2.5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) cyc <= cyc + 1;
  softstart_host host (.i_sys_clk(i_sys_clk), .o_enable(enable), .o_cmd(cmd));
  softstart_seq #(.MEM_CHECK_CYC(MC), .MIN_DELAY_CYC(MD), .CYC_PER_MS(CPM),
    .STEPS(ST)) dut (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_ce(1'b1),
    .i_enable(enable), .i_cmd(cmd), .i_trim_alt(trim_alt),
    .i_ss_strap(ss_strap), .i_voltage_select_low_pin(lo_pin),
    .i_voltage_select_high_pin(hi_pin), .i_nvm_wr(nvm_wr),
    .i_nvm_addr(nvm_addr), .i_nvm_wdata(nvm_wdata), .o_ready(ready),
    .o_ramping(ramping), .o_ramp_done(done),
    .o_undervoltage_lockout_level(undervoltage_lockout_level), .o_trim_mode(trim),
    .o_vref(vref), .o_target(target), .o_cfg(cfg));
  // ----------------------------------------------------------------------
  // compare tasks and reference model
  // ----------------------------------------------------------------------
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cfg(input softstart_pkg::ss_cfg_t got,
                         input softstart_pkg::ss_cfg_t exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_win(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  function automatic softstart_pkg::ss_cfg_t strap_cfg(
    input softstart_pkg::strap_t s);
    int ms[4];
    softstart_pkg::ss_cfg_t c;
    ms = '{2, 5, 10, 20};
    if (s.kind != softstart_pkg::STRAP_RES) begin
      c.delay_ms = 8'(ms[s.kind]);
      c.ramp_ms = c.delay_ms;
      c.undervoltage_lockout_level_high = 1'b0;
    end else begin
      c.delay_ms = (s.res_idx == 6'h00) ? 8'h00 : 8'(ms[s.res_idx[3:2]]);
      c.ramp_ms = 8'(ms[s.res_idx[1:0]]);
      c.undervoltage_lockout_level_high = s.res_idx[4];
    end
    return c;
  endfunction
  // ----------------------------------------------------------------------
  // stimulus tasks
  // ----------------------------------------------------------------------
  task automatic wait_ready();
    int n;
    n = 0;
    repeat (3) @(negedge i_sys_clk);
    while (ready !== 1'b1 && n < 400) begin
      @(negedge i_sys_clk);
      n++;
    end
  endtask
  task automatic restore();
    t0 = cyc;
    host.cmd(1'b0, 1'b1, 8'h00, 8'h00);
    wait_ready();
    chk_win(cyc - t0, MC, MC + 30);
  endtask
  task automatic nvm(input logic [1:0] a, input logic [15:0] d);
    @(negedge i_sys_clk);
    nvm_wr <= 1'b1;
    nvm_addr <= a;
    nvm_wdata <= d;
    @(negedge i_sys_clk);
    nvm_wr <= 1'b0;
  endtask
  task automatic run_en(input int dly, input int rmp, input bit abort);
    int n, m, e;
    n = 0;
    m = 0;
    e = (dly * CPM > MD) ? dly * CPM : MD;
    host.set_en(1'b1);
    while (ramping !== 1'b1 && n < 3000) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk_win(n, e, e + 6);
    if (!abort) begin
      while (done !== 1'b1 && m < 3000) begin
        @(negedge i_sys_clk);
        m++;
      end
      e = ST * ((rmp * CPM / ST > 0) ? rmp * CPM / ST : 1);
      chk_win(m, e - 3, e + 3);
      chk_val(vref, target);
    end
    host.set_en(1'b0);
    repeat (6) @(negedge i_sys_clk);
    chk_val(vref, 0);
    chk_val(done, 0);
  endtask
  task automatic wrap_up();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
  // main sequence
  initial begin
    softstart_pkg::ss_cfg_t ec;
    int d;
    int r;
    ss_strap = '{softstart_pkg::STRAP_OPEN, 6'h00};
    lo_pin = '{softstart_pkg::STRAP_LOW, 6'h00};
    hi_pin = '{softstart_pkg::STRAP_OPEN, 6'h00};
    repeat (12) @(negedge i_sys_clk);
    i_reset = 1'b0;
    t0 = cyc;
    host.set_en(1'b1);
    host.cmd(1'b1, 1'b0, 8'h01, 8'h01);
    host.set_en(1'b0);
    wait_ready();
    chk_win(cyc - t0, MC, MC + 30);
    chk_cfg(cfg, strap_cfg(ss_strap));
    chk_val(target, 600 + 300 * 3);
    chk_val(trim, 0);
    $display("test startup done");
    for (int k = 0; k < 4; k++) begin
      ec = cfg;
      @(negedge i_sys_clk);
      ss_strap.kind = softstart_pkg::strap_kind_t'(k);
      ss_strap.res_idx = 6'h15;
      repeat (4) @(negedge i_sys_clk);
      chk_cfg(cfg, ec);
      restore();
      ec = strap_cfg(ss_strap);
      chk_cfg(cfg, ec);
      chk_val(undervoltage_lockout_level, ec.undervoltage_lockout_level_high);
      run_en(ec.delay_ms, ec.ramp_ms, k == 1);
    end
    $display("test straps done");
    dq = '{0, 1, 5};
    dq.push_back($unsigned($random(seed)) % 8);
    dq.push_back($unsigned($random(seed)) % 8);
    foreach (dq[i]) begin
      d = dq[i];
      r = 1 + $unsigned($random(seed)) % 5;
      host.cmd(1'b1, 1'b0, 8'(d), 8'(r));
      chk_cfg(cfg, '{8'(d), 8'(r), 1'b1});
      run_en(d, r, 1'b0);
    end
    $display("test custom done");
    nvm(2'h0, 16'h0003);
    nvm(2'h1, 16'h0002);
    nvm(2'h3, 16'h04b0);
    nvm(2'h2, softstart_pkg::NVM_VALID_MARK);
    restore();
    chk_val({cfg.delay_ms, cfg.ramp_ms}, 16'h0302);
    chk_val(target, 1200);
    run_en(3, 2, 1'b0);
    $display("test stored done");
    nvm(2'h2, 16'h0000);
    lo_pin = '{softstart_pkg::STRAP_RES, softstart_pkg::TRIM_MODE_IDX};
    hi_pin = '{softstart_pkg::STRAP_RES, 6'h02};
    for (int a = 0; a < 2; a++) begin
      trim_alt = a[0];
      restore();
      chk_val(trim, 1);
      chk_val(target, 690 + 6900000 / (7000 + (a ? 8660 : 10000)));
    end
    $display("test trim done");
    // a restore taken while the start delay runs reruns the check
    host.set_en(1'b1);
    repeat (30) @(negedge i_sys_clk);
    restore();
    chk_val(ramping, 0);
    host.set_en(1'b0);
    repeat (6) @(negedge i_sys_clk);
    chk_val(vref, 0);
    $display("test restore done");
    wrap_up();
  end
endmodule
